/* srx_checker.sv */
// Assertions on request and bus ports of the receiver.
// Assumes one clock domain with asynchronous active-low reset.
module srx_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic rx_irq,
  input wire logic err_irq,
  input wire logic wait_wake,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // No bus access in flight, so flags cannot be cleared
  logic quiet;
  assign quiet = s_axi_awready && s_axi_arready && !s_axi_awvalid
               && !s_axi_wvalid && !s_axi_arvalid;
  AST_WAKE_TERM: assert property (wait_wake == (wait_mode && !stop_mode
    && (rx_irq || err_irq))) else $error("wake request wrong");
  AST_STOP_NO_WAKE: assert property (stop_mode |-> !wait_wake)
    else $error("wake in stop mode");
  AST_RX_HOLD: assert property (rx_irq && quiet |=> rx_irq)
    else $error("receiver request dropped");
  AST_ERR_HOLD: assert property (err_irq && quiet |=> err_irq)
    else $error("error request dropped");
  AST_B_LATENCY: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped");
endmodule : srx_checker

bind srx_receiver srx_checker chk_u (.clk, .rst_n, .wait_mode, .stop_mode,
  .rx_irq, .err_irq, .wait_wake, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

/* srx_pkg.sv */
// Constants shared by the serial receiver: register map, field positions,
// reset values and sample-tick counts.
// Assumes a sample tick at sixteen times the baud rate from a baud generator.
package srx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [5:0] OFF_CONTROL   = 6'h00;
  localparam logic [5:0] OFF_IRQ_EN    = 6'h04;
  localparam logic [5:0] OFF_STATUS    = 6'h08;
  localparam logic [5:0] OFF_RX_DATA   = 6'h0c;

  // Control register fields
  localparam int CTL_CHAR_LEN9     = 0;
  localparam int CTL_WAKE_ADDR     = 1;
  localparam int CTL_IDLE_START    = 2;
  localparam int CTL_PARITY_EN     = 3;
  localparam int CTL_PARITY_ODD    = 4;
  localparam int CTL_STANDBY       = 5;

  // Flag positions, shared by the status and interrupt enable registers; busy and standby bits are status only
  localparam int FLG_RX_FULL       = 0;
  localparam int FLG_IDLE          = 1;
  localparam int FLG_OVERRUN       = 2;
  localparam int FLG_NOISE         = 3;
  localparam int FLG_FRAMING       = 4;
  localparam int FLG_PARITY        = 5;
  localparam int STS_BUSY          = 8;
  localparam int STS_STANDBY       = 9;
  localparam int NUM_FLAGS         = 6;

  // Reset values
  localparam logic [5:0] CONTROL_RST = 6'h00;
  localparam logic [5:0] IRQ_EN_RST  = 6'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Sample-tick counts within one bit
  localparam logic [4:0] TICKS_PER_BIT = 5'h10;
  localparam logic [4:0] RT_EDGE_NEXT  = 5'h02;
  localparam logic [4:0] RT_FIRST      = 5'h01;
  localparam logic [4:0] RT_VER_A      = 5'h03;
  localparam logic [4:0] RT_VER_B      = 5'h05;
  localparam logic [4:0] RT_VER_C      = 5'h07;
  localparam logic [4:0] RT_MAJ_A      = 5'h08;
  localparam logic [4:0] RT_MAJ_B      = 5'h09;
  localparam logic [4:0] RT_MAJ_C      = 5'h0a;
  localparam logic [4:0] RT_EARLY_MIN  = 5'h0c;
  localparam logic [4:0] RT_LATE_MAX   = 5'h04;

  // Idle character lengths in bits and in ticks
  localparam int         IDLE_BITS_8   = 10;
  localparam int         IDLE_BITS_9   = 11;
  localparam logic [7:0] IDLE_TICKS_8  = 8'(IDLE_BITS_8 * 16);
  localparam logic [7:0] IDLE_TICKS_9  = 8'(IDLE_BITS_9 * 16);

  typedef enum logic [1:0] {
    SRX_SEARCH,
    SRX_START,
    SRX_DATA,
    SRX_STOP
  } srx_state_t;

endpackage : srx_pkg

/* srx_receiver.sv */
// Receive half of an asynchronous serial port with an AXI4-Lite register
// file, standby wakeup, receiver and error requests and low-power inputs.
// Assumes sample_tick is a one-cycle pulse on clk at sixteen times the baud
// rate, and wait_mode / stop_mode come from logic on the same clock.

//////////////////////////////////////////////////////////////////////////////
// Contract
// R1: Start passes if at most one of three checks is 1; single one flags noise.
// R2: Failed start verification resets tick counter and restarts start search.
// R3: Data bit is majority of ticks 8, 9, 10; disagreement flags noise.
// R4: Any 1 in start bit ticks 8-10 flags noise, start still accepted.
// R5: Stop sampled at 8, 9, 10; majority zero framing error, disagreement noise.
// R6: Framing error is set in the same cycle as receive-full.
// R7: Break character with zero stop position sets framing error.
// R8: Valid falling edges inside a character resynchronise the tick counter.
// R9: Stop sampling ends 154 ticks (8-bit) or 170 ticks (9-bit) after edge.
// R10: Standby request bit puts receiver in standby, suppressing all requests.
// R11: Address-mark wakeup: character with MSB 1 clears standby, sets full.
// R12: Idle wakeup: idle character clears standby, sets neither idle nor full.
// R13: Idle count start select picks counting after start or after stop.
// R14: Receive-full set on buffer transfer; requests receiver irq when enabled.
// R15: Idle flag after 10 or 11 ones; requests receiver irq when enabled.
// R16: Overrun keeps old character, drops new, flags; error irq when enabled.
// R17: Noise flag covers start, data, stop bits; error irq when enabled.
// R18: Framing flag requests error irq when enabled.
// R19: Parity mismatch sets parity flag; error irq when enabled.
// R20: In wait mode receiver runs; enabled requests end wait mode.
// R21: Stop mode halts with state kept, no wake; resumes afterwards.
// R22: Sample tick runs at sixteen times baud; line sampled once per tick.
// R23: Start search is zero after three ones; edge starts tick counting.
// R24: Start verification uses samples at ticks 3, 5, 7 after edge.
// R25: Character length select chooses 8-bit or 9-bit characters.
// R26: Separate receiver and error request outputs, OR of enabled flags.
module srx_receiver #(
  parameter int ADDR_W = 6
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Serial line and sample tick
  input  wire logic              rx_pin,
  input  wire logic              sample_tick,
  // Low-power modes
  input  wire logic              wait_mode,
  input  wire logic              stop_mode,
  // Requests
  output logic                   rx_irq,
  output logic                   err_irq,
  output logic                   wait_wake,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data and response
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [5:0]        off);
    reg_hit = (ADDR_W'(addr[ADDR_W-1:2]) == ADDR_W'(off[5:2]));
  endfunction : reg_hit

  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction : maj3

  function automatic logic differ3(input logic a, input logic b,
                                   input logic c);
    differ3 = ~((a & b & c) | ~(a | b | c));
  endfunction : differ3

  //////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                 rx_meta_r, rx_s_r;
  logic                 tick;
  srx_pkg::srx_state_t  state_r;
  logic [4:0]           rt_r;
  logic [3:0]           bit_idx_r;
  logic [2:0]           hist_r;
  logic [1:0]           ver_r, mj_r;
  logic                 last_maj_r;
  logic [8:0]           shift_r;
  logic                 par_r, nz_r;
  logic [3:0]           ones_run_r;
  logic [7:0]           idle_cnt_r;
  logic                 idle_armed_r;
  logic [8:0]           rx_data_buffer_r;
  logic [5:0]           ctrl_r, irq_en_r, flags_r;
  logic [5:0]           flag_set, flag_clr;
  logic                 aw_hold_r, w_hold_r;
  logic [ADDR_W-1:0]    aw_addr_r;
  logic [31:0]          w_data_r;
  logic                 w_strb0_r;
  logic                 wr_fire, rd_fire, data_read;
  logic                 len9, standby_request, idle_wake_sel;
  logic [3:0]           n_bits;
  logic [7:0]           idle_thr;
  logic [1:0]           ver_ones;
  logic                 maj_now, differ_now, at_maj, edge_ok, early, late;
  logic                 start_edge, start_fail, bit_end, char_done;
  logic                 ctl_wr, sts_wr, standby_wake, char_accept;
  logic                 idle_hit, idle_wake, fe_now, pe_now, msb_now;
  logic [31:0]          rd_mux;
  logic                 rd_ok;

  //////////////////////////////////////////////////////////////////////////
  // Line synchroniser; idle line reads 1 out of reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta_r <= 1'b1;
      rx_s_r    <= 1'b1;
    end else begin
      rx_meta_r <= rx_pin;
      rx_s_r    <= rx_meta_r;
    end
  end

  // Stop mode gates the tick, so every counter freezes in place
  assign tick = sample_tick & ~stop_mode;  // [R21] [R22]

  //////////////////////////////////////////////////////////////////////////
  // Configuration decode
  assign len9            = ctrl_r[srx_pkg::CTL_CHAR_LEN9];
  assign standby_request = ctrl_r[srx_pkg::CTL_STANDBY];
  assign idle_wake_sel   = ~ctrl_r[srx_pkg::CTL_WAKE_ADDR];
  assign n_bits          = len9 ? 4'h9 : 4'h8;  // [R25]
  assign idle_thr        = len9 ? srx_pkg::IDLE_TICKS_9
                                : srx_pkg::IDLE_TICKS_8;  // [R15]

  // Sample decisions
  assign ver_ones   = 2'(ver_r[0]) + 2'(ver_r[1]) + 2'(rx_s_r);
  assign maj_now    = maj3(mj_r[0], mj_r[1], rx_s_r);  // [R3]
  assign differ_now = differ3(mj_r[0], mj_r[1], rx_s_r);
  assign at_maj     = tick && (rt_r == srx_pkg::RT_MAJ_C);
  assign start_edge = tick && (state_r == srx_pkg::SRX_SEARCH) &&
                      (hist_r == 3'h7) && !rx_s_r;  // [R23]
  assign start_fail = tick && (state_r == srx_pkg::SRX_START) &&
                      (rt_r == srx_pkg::RT_VER_C) &&
                      (ver_ones > 2'h1);  // [R1] [R24]

  // A falling edge after a recovered 1 realigns the sample-tick counter
  assign edge_ok = tick && ((state_r == srx_pkg::SRX_DATA) ||
                            (state_r == srx_pkg::SRX_STOP)) &&
                   last_maj_r && hist_r[0] && !rx_s_r;  // [R8]
  assign early   = edge_ok && (state_r == srx_pkg::SRX_DATA) &&
                   (rt_r >= srx_pkg::RT_EARLY_MIN);
  assign late    = edge_ok && (rt_r <= srx_pkg::RT_LATE_MAX);
  assign bit_end = (tick && (rt_r == srx_pkg::TICKS_PER_BIT)) || early;
  assign char_done = at_maj && (state_r == srx_pkg::SRX_STOP);  // [R9]

  // End-of-character outcome
  assign fe_now  = ~maj_now;  // [R5] [R7]
  assign pe_now  = ctrl_r[srx_pkg::CTL_PARITY_EN] &&
                   (par_r != ctrl_r[srx_pkg::CTL_PARITY_ODD]);  // [R19]
  assign msb_now = shift_r[8];
  assign standby_wake = char_done && standby_request && !idle_wake_sel &&
                        msb_now;  // [R11]
  assign char_accept  = char_done && (!standby_request || standby_wake);

  //////////////////////////////////////////////////////////////////////////
  // Receive state machine and sample-tick counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= srx_pkg::SRX_SEARCH;
      rt_r      <= 5'h00;
      bit_idx_r <= 4'h0;
    end else if (tick) begin
      unique case (state_r)
        srx_pkg::SRX_SEARCH: begin
          if (start_edge) begin
            state_r <= srx_pkg::SRX_START;
            rt_r    <= srx_pkg::RT_EDGE_NEXT;
          end
        end
        srx_pkg::SRX_START: begin
          if (start_fail) begin
            state_r <= srx_pkg::SRX_SEARCH;  // [R2]
            rt_r    <= 5'h00;
          end else if (bit_end) begin
            state_r   <= srx_pkg::SRX_DATA;
            rt_r      <= srx_pkg::RT_FIRST;
            bit_idx_r <= 4'h1;
          end else begin
            rt_r <= rt_r + 5'h01;
          end
        end
        srx_pkg::SRX_DATA: begin
          if (bit_end) begin
            rt_r      <= early ? srx_pkg::RT_EDGE_NEXT : srx_pkg::RT_FIRST;
            bit_idx_r <= bit_idx_r + 4'h1;
            if (bit_idx_r == n_bits) begin
              state_r <= srx_pkg::SRX_STOP;
            end
          end else if (late) begin
            rt_r <= srx_pkg::RT_EDGE_NEXT;  // [R8]
          end else begin
            rt_r <= rt_r + 5'h01;
          end
        end
        srx_pkg::SRX_STOP: begin
          if (char_done) begin
            state_r <= srx_pkg::SRX_SEARCH;
            rt_r    <= 5'h00;
          end else if (late) begin
            rt_r <= srx_pkg::RT_EDGE_NEXT;
          end else begin
            rt_r <= rt_r + 5'h01;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sample capture, shift register, parity and per-character noise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_r     <= 3'h0;
      ver_r      <= 2'h0;
      mj_r       <= 2'h0;
      last_maj_r <= 1'b0;
      shift_r    <= 9'h000;
      par_r      <= 1'b0;
      nz_r       <= 1'b0;
      ones_run_r <= 4'h0;
    end else if (tick) begin
      hist_r <= {hist_r[1:0], rx_s_r};
      if (start_edge) begin
        nz_r       <= 1'b0;
        par_r      <= 1'b0;
        shift_r    <= 9'h000;
        last_maj_r <= 1'b0;
        ones_run_r <= 4'h0;
      end
      if (state_r == srx_pkg::SRX_START) begin
        if (rt_r == srx_pkg::RT_VER_A) ver_r[0] <= rx_s_r;  // [R24]
        if (rt_r == srx_pkg::RT_VER_B) ver_r[1] <= rx_s_r;
        if (rt_r == srx_pkg::RT_VER_C && ver_ones == 2'h1) begin
          nz_r <= 1'b1;  // [R1]
        end
        if (rt_r >= srx_pkg::RT_MAJ_A && rt_r <= srx_pkg::RT_MAJ_C &&
            rx_s_r) begin
          nz_r <= 1'b1;  // [R4]
        end
      end else begin
        if (rt_r == srx_pkg::RT_MAJ_A) mj_r[0] <= rx_s_r;
        if (rt_r == srx_pkg::RT_MAJ_B) mj_r[1] <= rx_s_r;
        if (rt_r == srx_pkg::RT_MAJ_C &&
            (state_r == srx_pkg::SRX_DATA ||
             state_r == srx_pkg::SRX_STOP)) begin
          last_maj_r <= maj_now;
          ones_run_r <= maj_now ? ones_run_r + 4'h1 : 4'h0;
          if (differ_now) nz_r <= 1'b1;  // [R3] [R5]
          if (state_r == srx_pkg::SRX_DATA) begin
            shift_r <= {maj_now, shift_r[8:1]};  // [R25]
            par_r   <= par_r ^ maj_now;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Idle line detection; the select bit decides what the run may include
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_r   <= 8'h00;
      idle_armed_r <= 1'b0;
    end else begin
      if (char_done) begin
        idle_cnt_r   <= ctrl_r[srx_pkg::CTL_IDLE_START] ? 8'h00
                        : {(maj_now ? ones_run_r + 4'h1 : 4'h0),
                           4'h0};  // [R13]
        idle_armed_r <= 1'b1;
      end else if (tick && state_r == srx_pkg::SRX_SEARCH) begin
        if (!rx_s_r) begin
          idle_cnt_r <= 8'h00;
        end else if (idle_cnt_r < idle_thr) begin
          idle_cnt_r <= idle_cnt_r + 8'h01;
        end
      end
      if (idle_hit || idle_wake) idle_armed_r <= 1'b0;
    end
  end

  // Idle wake needs no arming, so standby set on a quiet line wakes at once
  assign idle_wake = standby_request && idle_wake_sel &&
                     (idle_cnt_r >= idle_thr);  // [R12]
  assign idle_hit  = idle_armed_r && !(standby_request && idle_wake_sel) &&
                     (idle_cnt_r >= idle_thr);  // [R15]

  //////////////////////////////////////////////////////////////////////////
  // Data buffer; an unread character is kept and the new one dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_buffer_r <= 9'h000;
    end else if (char_accept && !flags_r[srx_pkg::FLG_RX_FULL]) begin
      rx_data_buffer_r <= len9 ? shift_r : {1'b0, shift_r[8:1]};  // [R14]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status flags: set beats a same-cycle clear
  always_comb begin
    flag_set = '0;
    if (char_accept) begin
      if (flags_r[srx_pkg::FLG_RX_FULL]) begin
        flag_set[srx_pkg::FLG_OVERRUN] = 1'b1;  // [R16]
      end else begin
        flag_set[srx_pkg::FLG_RX_FULL] = 1'b1;  // [R14] [R11]
        flag_set[srx_pkg::FLG_FRAMING] = fe_now;  // [R6] [R5]
        flag_set[srx_pkg::FLG_NOISE]   = nz_r | differ_now;  // [R17]
        flag_set[srx_pkg::FLG_PARITY]  = pe_now;
      end
    end
    flag_set[srx_pkg::FLG_IDLE] = idle_hit;  // [R15]
  end

  always_comb begin
    flag_clr = (sts_wr && w_strb0_r) ? w_data_r[5:0] : 6'h00;
    flag_clr[srx_pkg::FLG_RX_FULL] = data_read;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= 6'h00;
    end else begin
      flags_r <= (flags_r & ~flag_clr) | flag_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control and enable registers; wakeup clears the standby request
  assign ctl_wr = wr_fire && w_strb0_r && reg_hit(aw_addr_r,
                                                  srx_pkg::OFF_CONTROL);
  assign sts_wr = wr_fire && reg_hit(aw_addr_r, srx_pkg::OFF_STATUS);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r   <= srx_pkg::CONTROL_RST;
      irq_en_r <= srx_pkg::IRQ_EN_RST;
    end else begin
      if (ctl_wr) begin
        ctrl_r <= w_data_r[5:0];  // [R10]
      end else if (standby_wake || idle_wake) begin
        ctrl_r[srx_pkg::CTL_STANDBY] <= 1'b0;  // [R11] [R12]
      end
      if (wr_fire && w_strb0_r &&
          reg_hit(aw_addr_r, srx_pkg::OFF_IRQ_EN)) begin
        irq_en_r <= w_data_r[5:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Requests; standby hides them, stop mode keeps them from waking
  assign rx_irq  = !standby_request &&
                   |(flags_r[1:0] & irq_en_r[1:0]);  // [R26] [R10] [R14]
  assign err_irq = !standby_request &&
                   |(flags_r[5:2] & irq_en_r[5:2]);  // [R26] [R18] [R19]
  assign wait_wake = wait_mode && !stop_mode &&
                     (rx_irq || err_irq);  // [R20] [R21]

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data held until both arrive
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign wr_fire       = aw_hold_r && w_hold_r && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      aw_addr_r    <= '0;
      w_data_r     <= 32'h0000_0000;
      w_strb0_r    <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= srx_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r  <= 1'b1;
        w_data_r  <= s_axi_wdata;
        w_strb0_r <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (reg_hit(aw_addr_r, srx_pkg::OFF_CONTROL) ||
                         reg_hit(aw_addr_r, srx_pkg::OFF_IRQ_EN)  ||
                         reg_hit(aw_addr_r, srx_pkg::OFF_STATUS)  ||
                         reg_hit(aw_addr_r, srx_pkg::OFF_RX_DATA))
                        ? srx_pkg::RESP_OKAY : srx_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel; reading the buffer empties it
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign data_read     = rd_fire && reg_hit(s_axi_araddr,
                                            srx_pkg::OFF_RX_DATA);

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (reg_hit(s_axi_araddr, srx_pkg::OFF_CONTROL)) begin
      rd_mux[5:0] = ctrl_r;
    end else if (reg_hit(s_axi_araddr, srx_pkg::OFF_IRQ_EN)) begin
      rd_mux[5:0] = irq_en_r;
    end else if (reg_hit(s_axi_araddr, srx_pkg::OFF_STATUS)) begin
      rd_mux[5:0] = flags_r;
      rd_mux[srx_pkg::STS_BUSY]    = (state_r != srx_pkg::SRX_SEARCH);
      rd_mux[srx_pkg::STS_STANDBY] = standby_request;
    end else if (reg_hit(s_axi_araddr, srx_pkg::OFF_RX_DATA)) begin
      rd_mux[8:0] = rx_data_buffer_r;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= srx_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? srx_pkg::RESP_OKAY : srx_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : srx_receiver

/* srx_tx_model.sv */
// Remote transmitter model driving the receive line.
// Assumes tick is a one-cycle pulse at sixteen times the baud rate.
module srx_tx_model (
  // Clock and sample tick
  input  wire logic clk,
  input  wire logic tick,
  // Serial line
  output logic      line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line = 1'b1;
  // Sixteen ticks a bit, LSB first; the idle gap lets the search see ones
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n + 4; i++) begin
      line <= (i < n) ? f[i] : 1'b1;
      repeat (16) @(posedge clk iff tick);
    end
  endtask : send
endmodule : srx_tx_model

/* test_async_serial_receiver_recovery.sv */
// Self-checking bench for the serial receiver.
// Assumes the transmitter model and the bound checker.
module test_async_serial_receiver_recovery;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, tick, wait_mode, stop_mode, line, rx_irq, err_irq;
  logic        wake, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  tdiv, bresp, rresp;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  int          fail_count, compares;
  srx_receiver dut_u (.clk, .rst_n, .rx_pin(line), .sample_tick(tick),
    .wait_mode, .stop_mode, .rx_irq, .err_irq, .wait_wake(wake),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  srx_tx_model tx_u (.clk, .tick, .line);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Tick every fourth clock keeps frames short
  always @(posedge clk) begin
    tdiv <= tdiv + 2'h1;
    tick <= (tdiv == 2'h3);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    // Read data is taken at the edge where rvalid and rready meet
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, exp);
  endtask : rdc
  // Clears leftover flags so each scenario starts clean
  task automatic settle(input logic [31:0] d);
    repeat (200) @(posedge clk iff tick);
    rdc(6'h0c, d);
    wr(6'h08, 32'h3f);
  endtask : settle
  task automatic t_char8();
    rdc(6'h00, 32'h0);
    rdc(6'h10, 32'h0);
    chk({30'h0, rresp}, 32'h2);
    wr(6'h10, 32'h3f);
    chk({30'h0, bresp}, 32'h2);
    wr(6'h04, 32'h3);
    tx_u.send(11'h34a, 10);
    chk({31'h0, rx_irq}, 32'h1);
    rdc(6'h08, 32'h1);
    rdc(6'h0c, 32'ha5);
    repeat (200) @(posedge clk iff tick);
    rdc(6'h08, 32'h2);
  endtask : t_char8
  task automatic t_break();
    settle(32'ha5);
    wr(6'h04, 32'h14);
    tx_u.send(11'h0, 10);
    rdc(6'h08, 32'h11);
    chk({31'h0, err_irq}, 32'h1);
    tx_u.send(11'h278, 10);
    rdc(6'h08, 32'h15);
    rdc(6'h0c, 32'h0);
    wait_mode <= 1'b1;
    @(posedge clk);
    chk({31'h0, wake}, 32'h1);
    stop_mode <= 1'b1;
    @(posedge clk);
    chk({31'h0, wake}, 32'h0);
    wait_mode <= 1'b0;
    stop_mode <= 1'b0;
  endtask : t_break
  task automatic t_wake();
    settle(32'h0);
    wr(6'h04, 32'h1);
    wr(6'h00, 32'h22);
    tx_u.send(11'h20a, 10);
    chk({31'h0, rx_irq}, 32'h0);
    rdc(6'h08, 32'h200);
    tx_u.send(11'h30a, 10);
    rdc(6'h08, 32'h1);
    rdc(6'h00, 32'h2);
    rdc(6'h0c, 32'h85);
    settle(32'h85);
    wr(6'h00, 32'h1);
    tx_u.send(11'h74a, 11);
    rdc(6'h08, 32'h1);
    rdc(6'h0c, 32'h1a5);
    // Idle wake on a quiet line: standby drops, no idle or full flag
    wr(6'h00, 32'h20);
    repeat (100) @(posedge clk iff tick);
    rdc(6'h00, 32'h0);
    rdc(6'h08, 32'h0);
    wr(6'h00, 32'h18);
    tx_u.send(11'h34a, 10);
    rdc(6'h08, 32'h21);
  endtask : t_wake
  task automatic stop_test();
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    {rst_n, tdiv, tick, wait_mode, stop_mode, awvalid, wvalid} = '0;
    {bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    fail_count = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (40) @(posedge clk);
    t_char8();
    t_break();
    t_wake();
    stop_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    stop_test();
  end
endmodule : test_async_serial_receiver_recovery
